// ===== bench/host_model.sv
// host model driving the register interface
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic        clk,       // system clock
	output logic             reg_wr,    // write strobe
	output logic             reg_rd,    // read strobe
	output logic      [7:0]  reg_addr,  // address
	output logic      [15:0] reg_wdata, // write data
	input  wire logic [15:0] reg_rdata  // read data
);
	// idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
	end
	// one write; an idle edge first keeps strobes apart
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		#1 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1 reg_wr = 1'b0;
		reg_wdata = ~d; // stale data not held
	endtask : wr
	// one read; data taken an edge after the strobe
	task rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		#1 reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		@(posedge clk);
		#1 d = reg_rdata;
	endtask : rd
endmodule : host_model
`default_nettype wire

// ===== bench/limit_switch_fault_handler_bench.sv
// self-checking bench for the limit switch fault handler
`timescale 1ns/1ps
`default_nettype none
module limit_switch_fault_handler_bench;
	localparam int N = 3; // shortened persistence count
	logic        clk = 1'b0, reset_n = 1'b0, raw = 1'b0, other = 1'b0, sel = 1'b0;
	logic        wr, rd, dis, shd, irq, flt_n, oe;
	logic [7:0]  addr;
	logic [15:0] wdata, rdata, got;
	int          errors = 0, tests_run = 0;
	// rows: response code, expected disable, expected shutdown
	logic [3:0]  rows [4] = '{4'h0, 4'h6, 4'h9, 4'hd};
	always #5 clk = ~clk;
	limit_switch_fault_handler #(.PERSIST_CYCLES(16'(N))) i_dut (.CLK(clk), .RESET_N(reset_n), .REG_WR(wr),
		.REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .SWITCH_OC_RAW(raw),
		.OTHER_SUPPLY_FAULT(other), .FAULT_PIN_SELECT(sel), .SWITCH_DISABLE(dis), .SHUTDOWN_REQ(shd),
		.OVERCURRENT_GROUP_IRQ(irq), .SUPPLY_FAULT_N(flt_n), .SUPPLY_FAULT_OE(oe));
	host_model i_host (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata));
	task chk_reg(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_reg
	task chk_pin(input logic g, input logic e);
		chk_reg({15'h0000, g}, {15'h0000, e});
	endtask : chk_pin
	task give_verdict;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	// watchdog
	initial begin
		#20000;
		errors++;
		give_verdict;
	end
	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		#1 reset_n = 1'b1;
		sel = 1'b1;
		i_host.rd(8'hc7, got); chk_reg(got, 16'h0003);
		i_host.rd(8'hd7, got); chk_reg(got, 16'h0000);
		i_host.rd(8'h5d, got); chk_reg(got, 16'h0000);
		i_host.rd(8'h1d, got); chk_reg(got, 16'h0000);
		i_host.rd(8'h33, got); chk_reg(got, 16'h0000);
		chk_pin(oe, 1'b1);
		foreach (rows[i]) begin
			i_host.wr(8'hc7, {rows[i][3:2], 14'h0003});
			raw = 1'b1;
			repeat (N + 4) @(posedge clk);
			#1 chk_pin(dis, rows[i][1]);
			chk_pin(shd, rows[i][0]);
			chk_pin(flt_n, 1'b0);
			chk_pin(irq, 1'b1);
			i_host.rd(8'h1d, got); chk_reg(got, 16'h8000);
			i_host.rd(8'h1d, got); chk_reg(got, 16'h0000);
			chk_pin(irq, 1'b0);
			raw = 1'b0;
			repeat (3) @(posedge clk);
			#1 chk_pin(dis | shd | ~flt_n, 1'b0);
		end
		// pulse one sample short of qualifying
		raw = 1'b1;
		repeat (N - 1) @(posedge clk);
		#1 raw = 1'b0;
		repeat (4) @(posedge clk);
		#1 chk_pin(shd | ~flt_n, 1'b0);
		i_host.rd(8'h1d, got); chk_reg(got, 16'h0000);
		// event and pin masks set
		i_host.wr(8'h5d, 16'h8000);
		i_host.wr(8'hd7, 16'h8000);
		raw = 1'b1;
		repeat (N + 4) @(posedge clk);
		#1 chk_pin(irq, 1'b0);
		chk_pin(flt_n, 1'b1);
		i_host.rd(8'h1d, got); chk_reg(got, 16'h8000);
		raw = 1'b0;
		other = 1'b1;
		repeat (2) @(posedge clk);
		#1 chk_pin(flt_n, 1'b0);
		other = 1'b0;
		// mid-run reset with the pin deselected and a fault pending
		raw = 1'b1;
		sel = 1'b0;
		repeat (N + 4) @(posedge clk);
		#1 chk_pin(oe, 1'b0);
		chk_pin(shd, 1'b1);
		reset_n = 1'b0;
		raw = 1'b0;
		sel = 1'b1;
		#1 chk_reg({11'h000, dis, shd, irq, flt_n, oe}, 16'h0002);
		chk_reg(rdata, 16'h0000);
		repeat (2) @(posedge clk);
		#1 reset_n = 1'b1;
		i_host.rd(8'hc7, got); chk_reg(got, 16'h0003);
		i_host.rd(8'hd7, got); chk_reg(got, 16'h0000);
		i_host.rd(8'h5d, got); chk_reg(got, 16'h0000);
		i_host.rd(8'h1d, got); chk_reg(got, 16'h0000);
		chk_pin(oe, 1'b1);
		give_verdict;
	end
endmodule : limit_switch_fault_handler_bench
`default_nettype wire

// ===== bench/lsfh_checker_assertions.sv
// port checker for the limit switch fault handler
`timescale 1ns/1ps
`default_nettype none
module lsfh_checker (
	input wire logic        CLK,                   // system clock
	input wire logic        RESET_N,               // async reset, active low
	input wire logic        REG_WR,                // write strobe
	input wire logic        REG_RD,                // read strobe
	input wire logic [7:0]  REG_ADDR,              // address
	input wire logic [15:0] REG_WDATA,             // write data
	input wire logic        SWITCH_OC_RAW,         // raw over-current
	input wire logic        OTHER_SUPPLY_FAULT,    // other supply fault
	input wire logic        FAULT_PIN_SELECT,      // pin select
	input wire logic        SWITCH_DISABLE,        // switch forced off
	input wire logic        SHUTDOWN_REQ,          // shutdown request
	input wire logic        OVERCURRENT_GROUP_IRQ, // group interrupt
	input wire logic        SUPPLY_FAULT_N,        // fault pin level
	input wire logic        SUPPLY_FAULT_OE        // fault pin enable
);
	logic [1:0] resp;
	logic       imask, fmask;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// shadow of the written settings
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			resp <= 2'h0;
			imask <= 1'b0;
			fmask <= 1'b0;
		end else if (REG_WR) begin
			if (REG_ADDR == 8'hc7) resp <= REG_WDATA[15:14];
			if (REG_ADDR == 8'h5d) imask <= REG_WDATA[15];
			if (REG_ADDR == 8'hd7) fmask <= REG_WDATA[15];
		end
	end
	// unmasked switch fault reaching the pin
	sequence s_fault_rise;
		$fell(SUPPLY_FAULT_N) && !$past(OTHER_SUPPLY_FAULT) && !$past(fmask, 2) && !imask;
	endsequence
	a_persist_filter: assert property (
		$rose(SWITCH_DISABLE) |-> $past(SWITCH_OC_RAW, 2) && $past(SWITCH_OC_RAW, 3)
		&& $past(SWITCH_OC_RAW, 4)) else $error("no persistence");
	a_ignore_code: assert property (
		resp == 2'h0 && $past(resp) == 2'h0 |-> !SWITCH_DISABLE && !SHUTDOWN_REQ) else $error("ignore acted");
	a_disable_code: assert property ($rose(SWITCH_DISABLE) |-> $past(resp) == 2'h1)
		else $error("disable with wrong code");
	a_shutdown_code: assert property ($rose(SHUTDOWN_REQ) |-> $past(resp[1]))
		else $error("shutdown with wrong code");
	a_irq_follows: assert property (s_fault_rise |-> ##1 OVERCURRENT_GROUP_IRQ)
		else $error("event missed");
	a_read_clear: assert property (REG_RD && REG_ADDR == 8'h1d |-> ##2 !OVERCURRENT_GROUP_IRQ)
		else $error("event not cleared");
	a_irq_masked: assert property (imask && $past(imask) |-> !OVERCURRENT_GROUP_IRQ)
		else $error("masked event raised irq");
	a_other_fault: assert property ($past(OTHER_SUPPLY_FAULT) |-> !SUPPLY_FAULT_N)
		else $error("other fault not on pin");
	a_fault_excluded: assert property (
		fmask && $past(fmask) && !$past(OTHER_SUPPLY_FAULT) |-> SUPPLY_FAULT_N) else $error("masked fault on pin");
	a_pin_enable: assert property ($past(RESET_N) |-> SUPPLY_FAULT_OE == $past(FAULT_PIN_SELECT))
		else $error("pin enable wrong");
endmodule : lsfh_checker
bind limit_switch_fault_handler lsfh_checker i_check (
	.CLK                   (CLK),
	.RESET_N               (RESET_N),
	.REG_WR                (REG_WR),
	.REG_RD                (REG_RD),
	.REG_ADDR              (REG_ADDR),
	.REG_WDATA             (REG_WDATA),
	.SWITCH_OC_RAW         (SWITCH_OC_RAW),
	.OTHER_SUPPLY_FAULT    (OTHER_SUPPLY_FAULT),
	.FAULT_PIN_SELECT      (FAULT_PIN_SELECT),
	.SWITCH_DISABLE        (SWITCH_DISABLE),
	.SHUTDOWN_REQ          (SHUTDOWN_REQ),
	.OVERCURRENT_GROUP_IRQ (OVERCURRENT_GROUP_IRQ),
	.SUPPLY_FAULT_N        (SUPPLY_FAULT_N),
	.SUPPLY_FAULT_OE       (SUPPLY_FAULT_OE)
);
`default_nettype wire

// ===== src/limit_switch_fault_handler.sv
// limit switch over-current fault handling, event flag and supply-fault output
`timescale 1ns/1ps
`default_nettype none
`include "limit_switch_params.svh"

// Functional notes
// - Over-current is reported only after the raw condition persists.
// - Response field bits 15:14: 00 ignores, 01 disables the switch.
// - Response codes 10 and 11 request a full system shutdown.
// - Own first-level group holding the single switch over-current event.
// - Event flag bit 15 sets on the rising edge of qualified over-current.
// - Event flag clears automatically when software reads it.
// - Mask bit 15 set keeps the event from raising the group interrupt.
// - Supply-fault pin goes low on any regulator or converter fault, and on an unmasked switch fault.
// - Mask bit 15 clear lets switch over-current pull the supply-fault pin low.
// - Mask bit 15 set excludes switch faults; reset value is zero.
module limit_switch_fault_handler
	import limit_switch_pkg::*;
#(
	parameter logic [`PERSIST_CNT_W-1:0] PERSIST_CYCLES = `PERSIST_CNT_W'(`PERSIST_CYCLES_DEFAULT)
) (
	input  wire logic        CLK,                   // system clock, 100 MHz
	input  wire logic        RESET_N,               // async reset, active low
	input  wire logic        REG_WR,                // register write strobe
	input  wire logic        REG_RD,                // register read strobe
	input  wire logic [7:0]  REG_ADDR,              // register address
	input  wire logic [15:0] REG_WDATA,             // register write data
	output logic      [15:0] REG_RDATA,             // registered read data
	input  wire logic        SWITCH_OC_RAW,         // raw over-current from the switch
	input  wire logic        OTHER_SUPPLY_FAULT,    // regulator or converter fault
	input  wire logic        FAULT_PIN_SELECT,      // pin configured as supply-fault output
	output logic             SWITCH_DISABLE,        // force the limit switch off
	output logic             SHUTDOWN_REQ,          // system shutdown request
	output logic             OVERCURRENT_GROUP_IRQ, // first-level group interrupt
	output logic             SUPPLY_FAULT_N,        // supply-fault pin level, low on fault
	output logic             SUPPLY_FAULT_OE        // supply-fault pin drive enable
);
	logic [15:0]  limit_switch_control;
	logic [15:0]  supply_fault_output_config;
	logic [15:0]  switch_irq_mask;
	logic         oc_qualified;
	logic         switch_overcurrent_event;
	logic         status_read;
	oc_response_e overcurrent_response_select;

	assign overcurrent_response_select =
		oc_response_e'(limit_switch_control[`RESP_HI_BIT:`RESP_LO_BIT]);
	assign status_read = REG_RD && (REG_ADDR == `SWITCH_IRQ_STATUS_ADDR);

	// persistence filter on the raw condition
	oc_persist_filter #(
		.PERSIST_CYCLES(PERSIST_CYCLES)
	) u_filter (
		.clk       (CLK),
		.reset_n   (RESET_N),
		.raw_oc    (SWITCH_OC_RAW),
		.qualified (oc_qualified)
	);

	// the single second-level event of the group
	oc_event_flag u_event (
		.clk        (CLK),
		.reset_n    (RESET_N),
		.level      (oc_qualified),
		.read_clear (status_read),
		.flag       (switch_overcurrent_event)
	);

	// control register writes
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			limit_switch_control <= `LIMIT_SWITCH_CTRL_RESET;
		end else if (REG_WR && REG_ADDR == `LIMIT_SWITCH_CTRL_ADDR) begin
			limit_switch_control <= REG_WDATA;
		end
	end

	// supply-fault configuration writes
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			supply_fault_output_config <= `SUPPLY_FAULT_CFG_RESET;
		end else if (REG_WR && REG_ADDR == `SUPPLY_FAULT_CFG_ADDR) begin
			supply_fault_output_config <= REG_WDATA;
		end
	end

	// interrupt mask writes
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			switch_irq_mask <= `SWITCH_IRQ_MASK_RESET;
		end else if (REG_WR && REG_ADDR == `SWITCH_IRQ_MASK_ADDR) begin
			switch_irq_mask <= REG_WDATA;
		end
	end

	// registered read data, unmapped reads zero
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			REG_RDATA <= 16'h0000;
		end else if (REG_RD) begin
			if (REG_ADDR == `SWITCH_IRQ_STATUS_ADDR) begin
				REG_RDATA <= 16'h0000;
				REG_RDATA[`OC_EVENT_BIT] <= switch_overcurrent_event;
			end else if (REG_ADDR == `LIMIT_SWITCH_CTRL_ADDR) begin
				REG_RDATA <= limit_switch_control;
			end else if (REG_ADDR == `SUPPLY_FAULT_CFG_ADDR) begin
				REG_RDATA <= supply_fault_output_config;
			end else if (REG_ADDR == `SWITCH_IRQ_MASK_ADDR) begin
				REG_RDATA <= switch_irq_mask;
			end else begin
				REG_RDATA <= 16'h0000;
			end
		end
	end

	// fault response selection
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			SWITCH_DISABLE <= 1'b0;
			SHUTDOWN_REQ   <= 1'b0;
		end else begin
			case (overcurrent_response_select)
				RESP_IGNORE: begin
					SWITCH_DISABLE <= 1'b0;
					SHUTDOWN_REQ   <= 1'b0;
				end
				RESP_DISABLE: begin
					SWITCH_DISABLE <= oc_qualified;
					SHUTDOWN_REQ   <= 1'b0;
				end
				default: begin
					SWITCH_DISABLE <= 1'b0;
					SHUTDOWN_REQ   <= oc_qualified;
				end
			endcase
		end
	end

	// group interrupt gated by the mask
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			OVERCURRENT_GROUP_IRQ <= 1'b0;
		end else begin
			OVERCURRENT_GROUP_IRQ <= switch_overcurrent_event && !switch_irq_mask[`OC_MASK_BIT];
		end
	end

	// supply-fault pin, driven while selected
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			SUPPLY_FAULT_N  <= 1'b1;
			SUPPLY_FAULT_OE <= 1'b0;
		end else begin
			SUPPLY_FAULT_OE <= FAULT_PIN_SELECT;
			SUPPLY_FAULT_N  <= !(OTHER_SUPPLY_FAULT
				|| (oc_qualified && !supply_fault_output_config[`FAULT_OUT_MASK_BIT]));
		end
	end
endmodule : limit_switch_fault_handler
`default_nettype wire

// ===== src/limit_switch_params.svh
// register offsets, field positions, reset values and timing counts for the limit switch fault handler
`ifndef LIMIT_SWITCH_PARAMS_SVH
`define LIMIT_SWITCH_PARAMS_SVH

`define SWITCH_IRQ_STATUS_ADDR   8'h1d
`define LIMIT_SWITCH_CTRL_ADDR   8'hc7
`define SUPPLY_FAULT_CFG_ADDR    8'hd7
`define SWITCH_IRQ_MASK_ADDR     8'h5d
`define OC_EVENT_BIT             15
`define OC_MASK_BIT              15
`define FAULT_OUT_MASK_BIT       15
`define RESP_HI_BIT              15
`define RESP_LO_BIT              14
`define LIMIT_SWITCH_CTRL_RESET  16'h0003
`define SUPPLY_FAULT_CFG_RESET   16'h0000
`define SWITCH_IRQ_MASK_RESET    16'h0000
`define PERSIST_CYCLES_DEFAULT   16
`define PERSIST_CNT_W            16

`endif

// ===== src/limit_switch_pkg.sv
// types shared by the limit switch fault handler
package limit_switch_pkg;
	typedef enum logic [1:0] {
		RESP_IGNORE   = 2'h0,
		RESP_DISABLE  = 2'h1,
		RESP_SHUTDOWN = 2'h2,
		RESP_SHUTDN2  = 2'h3
	} oc_response_e;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'h1,
		ST_FILTER  = 3'h2,
		ST_QUALIFY = 3'h4
	} filter_state_e;
endpackage : limit_switch_pkg

// ===== src/oc_event_flag.sv
// rising-edge event flag with clear on read
`timescale 1ns/1ps
`default_nettype none
module oc_event_flag (
	input  wire logic clk,        // system clock
	input  wire logic reset_n,    // async reset, active low
	input  wire logic level,      // qualified condition level
	input  wire logic read_clear, // status read strobe
	output logic      flag        // sticky event flag
);
	logic level_d;

	// previous level for edge detection
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			level_d <= 1'b0;
		end else begin
			level_d <= level;
		end
	end

	// set on edge wins over the clear on read
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flag <= 1'b0;
		end else if (level && !level_d) begin
			flag <= 1'b1;
		end else if (read_clear) begin
			flag <= 1'b0;
		end
	end
endmodule : oc_event_flag
`default_nettype wire

// ===== src/oc_persist_filter.sv
// persistence filter that qualifies the raw over-current level
`timescale 1ns/1ps
`default_nettype none
`include "limit_switch_params.svh"
module oc_persist_filter
	import limit_switch_pkg::*;
#(
	parameter logic [`PERSIST_CNT_W-1:0] PERSIST_CYCLES = `PERSIST_CNT_W'(`PERSIST_CYCLES_DEFAULT)
) (
	input  wire logic clk,        // system clock
	input  wire logic reset_n,    // async reset, active low
	input  wire logic raw_oc,     // raw over-current comparator level
	output logic      qualified   // condition persisted
);
	filter_state_e            state;
	logic [`PERSIST_CNT_W-1:0] count;

	// consecutive-cycle count; any drop restarts it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			count <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					count <= '0;
					if (raw_oc) begin
						state <= ST_FILTER;
						count <= `PERSIST_CNT_W'(1);
					end
				end
				ST_FILTER: begin
					if (!raw_oc) begin
						state <= ST_IDLE;
					end else if (count >= PERSIST_CYCLES - `PERSIST_CNT_W'(1)) begin
						state <= ST_QUALIFY;
					end else begin
						count <= count + `PERSIST_CNT_W'(1);
					end
				end
				ST_QUALIFY: begin
					if (!raw_oc) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	assign qualified = (state == ST_QUALIFY);
endmodule : oc_persist_filter
`default_nettype wire
